// ==== hdl/cbp_pkg.sv ====
// Constants and types for the bus cycle and prefetch control block
// Overview of operation
// RQ1: With no wait, one opcode byte fetched per clock; fetch ends instruction.
// RQ2: Opcode fetch drives read strobe and fetch marker; memory read only strobe.
// RQ3: Memory read and write cycles last at least one clock plus waits.
// RQ4: I/O read and write cycles last at least two clocks plus waits.
// RQ5: Active low wait input holds the core in wait, stretching the cycle.
// RQ6: Every instruction ends with a prefetch; after a jump, from the target.
// RQ7: Normally the prefetched byte is kept and executed without refetch.
// RQ8: Interrupt entry discards the prefetched byte; it is refetched later.
// RQ9: On interrupt entry the saved program counter is decremented by one.
// RQ10: Either return from interrupt reloads the discarded byte's address.
// RQ11: Bus release keeps the prefetched byte; resume fetching after it.
// RQ12: Accepted bus request floats address, drops strobes, masks ints, grants.
// RQ13: Master holds request low; core stays released until request rises.
// RQ14: Bus granted only at instruction boundaries, except repeating ops.
// RQ15: Repeating block move may grant the bus after every iteration.
// RQ16: Carry flag takes carry out of bit 7 for add, subtract, shift, rotate; rotate right takes bit 0 instead.
// RQ17: Zero flag set when result is zero for the listed operations.
// RQ18: Sign flag set when signed result is negative.
// RQ19: Parity/overflow shows parity for logic ops, overflow for arithmetic.
// RQ20: Loading accumulator from page or refresh copies shadow enable to P/V.
// RQ21: Half carry set on carry out of or borrow into low nibble.
// RQ22: Subtract flag set by subtracts; decimal adjust reads it.
// RQ23: Flag layout: S7 Z6 H4 PV2 N1 C0.
// RQ24: Each sampled active wait adds one clock, strobes and address held.
package cbp_pkg;
   // ==========================================================
   // Cycle lengths and flag positions
   localparam logic [1:0] CBP_MEM_MIN   = 2'h1;
   localparam logic [1:0] CBP_IO_MIN    = 2'h2;
   localparam int         CBP_FL_S      = 7;
   localparam int         CBP_FL_Z      = 6;
   localparam int         CBP_FL_H      = 4;
   localparam int         CBP_FL_PV     = 2;
   localparam int         CBP_FL_N      = 1;
   localparam int         CBP_FL_C      = 0;
   localparam logic [15:0] CBP_PC_RESET = 16'h0000;
   localparam logic [7:0]  CBP_FLAG_RST = 8'h00;

   // ==========================================================
   // Bus cycle kinds requested by the sequencer
   typedef enum logic [2:0] {
      CBP_CYC_MRD  = 3'h0,
      CBP_CYC_MWR  = 3'h1,
      CBP_CYC_IO_READ_STROBE = 3'h2,
      CBP_CYC_IO_WRITE_STROBE = 3'h3
   } cbp_cyc_e;

   // ALU operations; all but CBP_OP_REPEAT_BLOCK_MOVE produce flags
   typedef enum logic [3:0] {
      CBP_OP_ADD  = 4'h0,
      CBP_OP_ADC  = 4'h1,
      CBP_OP_SUB  = 4'h2,
      CBP_OP_SBC  = 4'h3,
      CBP_OP_AND  = 4'h4,
      CBP_OP_OR   = 4'h5,
      CBP_OP_XOR  = 4'h6,
      CBP_OP_RL   = 4'h7,
      CBP_OP_RR   = 4'h8,
      CBP_OP_INC  = 4'h9,
      CBP_OP_DEC  = 4'hA,
      CBP_OP_REPEAT_BLOCK_MOVE = 4'hB
   } cbp_op_e;

   // Sequencer states, one-hot
   typedef enum logic [5:0] {
      CBP_ST_IDLE  = 6'h01,
      CBP_ST_FETCH = 6'h02,
      CBP_ST_DATA  = 6'h04,
      CBP_ST_WAIT  = 6'h08,
      CBP_ST_REL   = 6'h10,
      CBP_ST_EXEC  = 6'h20
   } cbp_st_e;
endpackage : cbp_pkg

// ==== hdl/cbp_flags.sv ====
// Flag generation for the accumulator ALU
`timescale 1ns/1ps
module cbp_flags
   import cbp_pkg::*;
(
   input  wire logic [3:0] op,
   input  wire logic [7:0] opa,
   input  wire logic [7:0] opb,
   input  wire logic       cin,
   input  wire logic       ld_special,
   input  wire logic       shadow_en,
   input  wire logic [7:0] flags_in,
   output logic      [7:0] result,
   output logic      [7:0] flags_out
);
   // ==========================================================
   // Arithmetic
   logic [8:0] sum;
   logic [4:0] half;
   logic       is_sub;
   logic       is_arith;
   logic       is_logic;
   logic       is_shift;
   logic       cy;
   logic       ov;
   logic       c_in_eff;

   assign is_sub   = (op == CBP_OP_SUB) || (op == CBP_OP_SBC) ||
                     (op == CBP_OP_DEC);
   assign is_logic = (op == CBP_OP_AND) || (op == CBP_OP_OR) ||
                     (op == CBP_OP_XOR);
   assign is_shift = (op == CBP_OP_RL) || (op == CBP_OP_RR);
   assign is_arith = !is_logic && !is_shift && (op != CBP_OP_REPEAT_BLOCK_MOVE);
   assign c_in_eff = ((op == CBP_OP_ADC) || (op == CBP_OP_SBC)) && cin;

   always_comb begin
      sum    = 9'h000;
      half   = 5'h00;
      result = opa;
      cy     = flags_in[CBP_FL_C];
      case (op)
         CBP_OP_ADD, CBP_OP_ADC, CBP_OP_INC: begin
            sum  = {1'b0, opa} + {1'b0, opb} + {8'h00, c_in_eff};
            half = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, c_in_eff};
            result = sum[7:0];
            cy     = (op == CBP_OP_INC) ? flags_in[CBP_FL_C] : sum[8]; // RQ16
         end
         CBP_OP_SUB, CBP_OP_SBC, CBP_OP_DEC: begin
            sum  = {1'b0, opa} - {1'b0, opb} - {8'h00, c_in_eff};
            half = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, c_in_eff};
            result = sum[7:0];
            cy     = (op == CBP_OP_DEC) ? flags_in[CBP_FL_C] : sum[8]; // RQ16
         end
         CBP_OP_AND: result = opa & opb;
         CBP_OP_OR:  result = opa | opb;
         CBP_OP_XOR: result = opa ^ opb;
         CBP_OP_RL: begin
            result = {opa[6:0], cin};
            cy     = opa[7]; // RQ16
         end
         CBP_OP_RR: begin
            result = {cin, opa[7:1]};
            cy     = opa[0]; // RQ16
         end
         default: result = opa;
      endcase
   end

   // Signed overflow: add operands alike in sign or subtract operands unlike, result sign differs from opa
   assign ov = is_sub ? ((opa[7] != opb[7]) && (result[7] != opa[7]))
                      : ((opa[7] == opb[7]) && (result[7] != opa[7])); // RQ19

   // ==========================================================
   // Flag assembly
   always_comb begin
      flags_out = flags_in;
      if (ld_special) begin
         flags_out[CBP_FL_S]  = opa[7];
         flags_out[CBP_FL_Z]  = (opa == 8'h00);
         flags_out[CBP_FL_PV] = shadow_en; // RQ20
      end else if (op != CBP_OP_REPEAT_BLOCK_MOVE) begin
         flags_out[CBP_FL_S] = result[7]; // RQ18
         flags_out[CBP_FL_Z] = (result == 8'h00); // RQ17
         flags_out[CBP_FL_C] = cy; // RQ16 RQ23
         flags_out[CBP_FL_H] = is_arith ? half[4] : (op == CBP_OP_AND); // RQ21
         flags_out[CBP_FL_N] = is_sub; // RQ22
         flags_out[CBP_FL_PV] = is_arith ? ov : ~^result; // RQ19
      end
   end
endmodule : cbp_flags

// ==== hdl/cbp_core.sv ====
// Bus cycle sequencer with prefetch, bus release and flag register
`timescale 1ns/1ps
module cbp_core
   import cbp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Instruction sequencer side
   input  wire logic        cyc_req,
   input  wire logic [2:0]  cyc_kind,
   input  wire logic [15:0] cyc_addr,
   input  wire logic [7:0]  cyc_wdata,
   input  wire logic        instr_end,
   input  wire logic        jump_take,
   input  wire logic [15:0] jump_target,
   input  wire logic        iter_end,
   input  wire logic        rep_move,
   input  wire logic        int_recog,
   input  wire logic        ret_int,
   input  wire logic        ret_nmi,
   input  wire logic [15:0] ret_addr,
   input  wire logic        interrupt_enable_shadow,
   // ALU side
   input  wire logic        alu_go,
   input  wire logic [3:0]  alu_op,
   input  wire logic [7:0]  alu_b,
   input  wire logic        ld_a_special,
   input  wire logic [7:0]  ld_a_value,
   // Bus side
   input  wire logic        wait_request_in,
   input  wire logic        bus_request_in,
   input  wire logic [7:0]  bus_rdata,
   output logic      [15:0] logical_address,
   output logic             addr_oe_n,
   output logic      [7:0]  bus_wdata,
   output logic             memory_read_strobe,
   output logic             memory_write_strobe,
   output logic             io_read_strobe,
   output logic             io_write_strobe,
   output logic             fetch_cycle_marker,
   output logic             bus_grant_out,
   output logic             int_block,
   // Status
   output logic             cyc_done,
   output logic      [7:0]  rdata,
   output logic      [7:0]  opcode,
   output logic             opcode_valid,
   output logic      [15:0] pc_out,
   output logic      [15:0] saved_pc,
   output logic      [7:0]  acc_out,
   output logic      [7:0]  flags_out
);
   // ==========================================================
   // State
   cbp_st_e     st_reg, st_next;
   logic [15:0] pc_reg, pc_next;
   logic [15:0] addr_reg;
   logic [2:0]  kind_reg;
   logic [1:0]  cnt_reg;
   logic [7:0]  wd_reg;
   logic [7:0]  op_reg;
   logic        opv_reg;
   logic [7:0]  rd_reg;
   logic        done_reg;
   logic [15:0] spc_reg;
   logic [7:0]  acc_reg;
   logic [7:0]  fl_reg;
   logic        is_io;
   logic        waiting;
   logic        last_clk;
   logic        boundary;
   logic        grant_ok;
   logic        fetch_go;
   logic [7:0]  alu_res;
   logic [7:0]  alu_fl;

   function automatic logic [1:0] min_len(input logic [2:0] k);
      min_len = (k == CBP_CYC_IO_READ_STROBE || k == CBP_CYC_IO_WRITE_STROBE) ?
                CBP_IO_MIN : CBP_MEM_MIN;
   endfunction : min_len

   assign is_io    = (kind_reg == CBP_CYC_IO_READ_STROBE) ||
                     (kind_reg == CBP_CYC_IO_WRITE_STROBE);
   assign waiting  = !wait_request_in; // RQ5 RQ24
   assign last_clk = (cnt_reg == 2'h1) && !waiting;
   // Repeating ops may release only per iteration
   assign boundary = instr_end || (rep_move && iter_end); // RQ14 RQ15
   assign grant_ok = !bus_request_in && boundary;
   assign fetch_go = instr_end && bus_request_in; // RQ6

   // ==========================================================
   // Sequencer
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         CBP_ST_IDLE, CBP_ST_EXEC: begin
            if (grant_ok)
               st_next = CBP_ST_REL; // RQ12 RQ14
            else if (fetch_go)
               st_next = CBP_ST_FETCH; // RQ1
            else if (cyc_req)
               st_next = CBP_ST_DATA;
         end
         CBP_ST_FETCH, CBP_ST_DATA: begin
            if (waiting || cnt_reg != 2'h1)
               st_next = st_reg; // RQ3 RQ4 RQ24
            else
               st_next = CBP_ST_EXEC;
         end
         CBP_ST_REL: begin
            if (bus_request_in)
               st_next = CBP_ST_FETCH; // RQ13 RQ11
         end
         default: st_next = CBP_ST_IDLE;
      endcase
   end

   // Program counter moves: jump, interrupt rewind, returns
   always_comb begin
      pc_next = pc_reg;
      if (ret_int || ret_nmi)
         pc_next = ret_addr; // RQ10
      else if (int_recog)
         pc_next = pc_reg - 16'h0001; // RQ8 RQ9
      else if (jump_take)
         pc_next = jump_target; // RQ6
      else if (st_reg == CBP_ST_FETCH && last_clk)
         pc_next = pc_reg + 16'h0001; // RQ11
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_reg <= CBP_ST_IDLE;
         pc_reg <= CBP_PC_RESET;
      end else begin
         st_reg <= st_next;
         pc_reg <= pc_next;
      end
   end

   // Cycle capture; address and strobes frozen during waits
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         addr_reg <= 16'h0000;
         kind_reg <= CBP_CYC_MRD;
         cnt_reg  <= 2'h0;
         wd_reg   <= 8'h00;
      end else if (st_next == CBP_ST_FETCH && st_reg != CBP_ST_FETCH) begin
         addr_reg <= pc_next;
         kind_reg <= CBP_CYC_MRD;
         cnt_reg  <= CBP_MEM_MIN;
      end else if (st_next == CBP_ST_DATA && st_reg != CBP_ST_DATA) begin
         addr_reg <= cyc_addr;
         kind_reg <= cyc_kind;
         cnt_reg  <= min_len(cyc_kind); // RQ3 RQ4
         wd_reg   <= cyc_wdata;
      end else if (!waiting && cnt_reg > 2'h1) begin
         cnt_reg <= cnt_reg - 2'h1; // RQ4
      end
   end

   // Prefetched opcode: kept normally, dropped on interrupt entry
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         op_reg   <= 8'h00;
         opv_reg  <= 1'b0;
         rd_reg   <= 8'h00;
         done_reg <= 1'b0;
         spc_reg  <= 16'h0000;
      end else begin
         done_reg <= (st_reg == CBP_ST_FETCH || st_reg == CBP_ST_DATA) &&
                     last_clk;
         if (int_recog) begin
            opv_reg <= 1'b0; // RQ8
            spc_reg <= pc_reg - 16'h0001; // RQ9
         end else if (st_reg == CBP_ST_FETCH && last_clk) begin
            op_reg  <= bus_rdata; // RQ7
            opv_reg <= 1'b1;
         end else if (cyc_req && st_reg == CBP_ST_EXEC) begin
            opv_reg <= 1'b0;
         end
         if (st_reg == CBP_ST_DATA && last_clk)
            rd_reg <= bus_rdata;
      end
   end

   // ==========================================================
   // Accumulator and flags
   cbp_flags u_flags (
      .op         (alu_op),
      .opa        (acc_reg),
      .opb        (alu_b),
      .cin        (fl_reg[CBP_FL_C]),
      .ld_special (ld_a_special),
      .shadow_en  (interrupt_enable_shadow),
      .flags_in   (fl_reg),
      .result     (alu_res),
      .flags_out  (alu_fl)
   );

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         acc_reg <= 8'h00;
         fl_reg  <= CBP_FLAG_RST;
      end else if (ld_a_special) begin
         acc_reg <= ld_a_value;
         fl_reg  <= alu_fl; // RQ20
      end else if (alu_go) begin
         acc_reg <= alu_res;
         fl_reg  <= alu_fl; // RQ16 RQ17 RQ19
      end
   end

   // ==========================================================
   // Outputs; strobes are active low
   wire act = (st_reg == CBP_ST_FETCH) || (st_reg == CBP_ST_DATA);
   wire rel = (st_reg == CBP_ST_REL);
   assign memory_read_strobe  = !(act && kind_reg == CBP_CYC_MRD); // RQ2
   assign memory_write_strobe = !(act && kind_reg == CBP_CYC_MWR);
   assign io_read_strobe      = !(act && kind_reg == CBP_CYC_IO_READ_STROBE);
   assign io_write_strobe     = !(act && kind_reg == CBP_CYC_IO_WRITE_STROBE);
   assign fetch_cycle_marker  = !(st_reg == CBP_ST_FETCH); // RQ2
   assign bus_grant_out       = !rel; // RQ12
   assign addr_oe_n           = rel; // RQ12
   assign int_block           = rel; // RQ12
   assign logical_address     = addr_reg;
   assign bus_wdata           = wd_reg;
   assign cyc_done            = done_reg;
   assign rdata               = rd_reg;
   assign opcode              = op_reg;
   assign opcode_valid        = opv_reg;
   assign pc_out              = pc_reg;
   assign saved_pc            = spc_reg;
   assign acc_out             = acc_reg;
   assign flags_out           = fl_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   fetch_marker_a: assert property (!fetch_cycle_marker |->
      !memory_read_strobe) else $error("marker without read"); // RQ2
   io_min_len_a: assert property ($fell(io_read_strobe) |->
      !io_read_strobe [*2]) else $error("io read too short"); // RQ4
   wait_hold_a: assert property ((act && waiting) |=>
      $stable(logical_address) && act) else $error("wait not held"); // RQ5
   release_a: assert property (rel |-> bus_request_in == 1'b0 ||
      $past(bus_request_in) == 1'b0) else $error("bad release"); // RQ13
   grant_bound_a: assert property ($fell(bus_grant_out) |->
      $past(boundary)) else $error("grant off boundary"); // RQ14
   int_drop_a: assert property (int_recog && !ret_int && !ret_nmi |=>
      !opcode_valid && pc_out == $past(pc_out) - 16'h0001)
      else $error("rewind missing"); // RQ8
   ret_load_a: assert property (ret_nmi |=> pc_out == $past(ret_addr))
      else $error("return pc wrong"); // RQ10
   rel_float_a: assert property (rel |-> addr_oe_n && memory_read_strobe &&
      io_write_strobe) else $error("bus not released"); // RQ12

   fetch_c: cover property (st_reg == CBP_ST_FETCH ##1 st_reg == CBP_ST_EXEC);
   io_wait_c: cover property (act && is_io && waiting);
   rel_c: cover property (rel ##1 st_reg == CBP_ST_FETCH);
endmodule : cbp_core

// ==== verif/cbp_bus_model.sv ====
// Far-side memory and I/O model with wait insertion
`timescale 1ns/1ps
module cbp_bus_model (
   input  wire logic        clk_sys,
   input  wire logic [15:0] logical_address,
   input  wire logic        memory_read_strobe,
   input  wire logic        memory_write_strobe,
   input  wire logic        io_read_strobe,
   input  wire logic        io_write_strobe,
   input  wire logic [2:0]  n_wait,
   output logic             wait_request_in,
   output logic      [7:0]  bus_rdata
);
   // ==========================================================
   // Cycle tracking
   // No initialisers: the clocked process drives cyc_cnt and last_rd, assigns drive the rest
   logic [2:0] cyc_cnt;
   logic [7:0] last_rd;
   logic       any_cyc;
   logic       rd_cyc;
   assign any_cyc = !(memory_read_strobe && memory_write_strobe
                      && io_read_strobe && io_write_strobe);
   assign rd_cyc  = !(memory_read_strobe && io_read_strobe);
   // Not ready for the first n_wait clocks of every cycle
   assign wait_request_in = !(any_cyc && (cyc_cnt < n_wait));
   // Unselected data lines show the inverse, never a stale match
   assign bus_rdata = rd_cyc ?
      (logical_address[7:0] ^ logical_address[15:8] ^ 8'hA5) : ~last_rd;
   always_ff @(posedge clk_sys) begin
      cyc_cnt <= any_cyc ? cyc_cnt + 3'h1 : 3'h0;
      last_rd <= bus_rdata;
   end
endmodule : cbp_bus_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the bus cycle and prefetch control block
`timescale 1ns/1ps
module tb_top
   import cbp_pkg::*;
();
   // ==========================================================
   // Signals
   logic        clk_sys = 1'b0, rstn = 1'b0;
   logic        cyc_req = 1'b0, instr_end = 1'b0, jump_take = 1'b0;
   logic        iter_end = 1'b0, rep_move = 1'b0, int_recog = 1'b0;
   logic        ret_int = 1'b0, ret_nmi = 1'b0, alu_go = 1'b0;
   logic        ld_a_special = 1'b0, interrupt_enable_shadow = 1'b0;
   logic        bus_request_in = 1'b1;
   logic [2:0]  cyc_kind = 3'h0, n_wait = 3'h0;
   logic [3:0]  alu_op = 4'h0;
   logic [7:0]  cyc_wdata = 8'h00, alu_b = 8'h00, ld_a_value = 8'h00;
   logic [15:0] cyc_addr = 16'h0000, jump_target = 16'h0000;
   logic [15:0] ret_addr = 16'h0000, p;
   logic        wait_request_in, addr_oe_n, memory_read_strobe;
   logic        memory_write_strobe, io_read_strobe, io_write_strobe;
   logic        fetch_cycle_marker, bus_grant_out, int_block, cyc_done;
   logic        opcode_valid;
   logic [7:0]  bus_rdata, bus_wdata, rdata, opcode, acc_out, flags_out;
   logic [15:0] logical_address, pc_out, saved_pc;
   logic [3:0]  strb;
   logic [3:0]  ops [3] = '{CBP_OP_ADD, CBP_OP_SUB, CBP_OP_XOR};
   int          n_fail = 0;
   int          comparisons = 0;
   assign strb = {io_write_strobe, io_read_strobe, memory_write_strobe,
                  memory_read_strobe};
   always #5 clk_sys = ~clk_sys;
   cbp_core dut (
      .clk_sys, .rstn, .cyc_req, .cyc_kind, .cyc_addr, .cyc_wdata,
      .instr_end, .jump_take, .jump_target, .iter_end, .rep_move,
      .int_recog, .ret_int, .ret_nmi, .ret_addr, .interrupt_enable_shadow,
      .alu_go, .alu_op, .alu_b, .ld_a_special, .ld_a_value,
      .wait_request_in, .bus_request_in, .bus_rdata, .logical_address,
      .addr_oe_n, .bus_wdata, .memory_read_strobe, .memory_write_strobe,
      .io_read_strobe, .io_write_strobe, .fetch_cycle_marker,
      .bus_grant_out, .int_block, .cyc_done, .rdata, .opcode,
      .opcode_valid, .pc_out, .saved_pc, .acc_out, .flags_out);
   cbp_bus_model u_mem (
      .clk_sys, .logical_address, .memory_read_strobe,
      .memory_write_strobe, .io_read_strobe, .io_write_strobe, .n_wait,
      .wait_request_in, .bus_rdata);
   // ==========================================================
   // Helpers
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction : pat
   function automatic logic [7:0] exp_flags(input int m,
      input logic [7:0] a, input logic [7:0] b, output logic [7:0] res);
      logic [8:0] r;
      logic [4:0] h;
      logic       sb;
      sb = (m == 1);
      r = sb ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
      h = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]}
             : {1'b0, a[3:0]} + {1'b0, b[3:0]};
      if (m == 2) r = {1'b0, a ^ b};
      res = r[7:0];
      exp_flags = 8'h00;
      exp_flags[CBP_FL_S] = r[7];
      exp_flags[CBP_FL_Z] = (r[7:0] == 8'h00);
      exp_flags[CBP_FL_H] = h[4];
      exp_flags[CBP_FL_PV] = (m == 2) ? ~^r[7:0]
         : (((a[7] ^ b[7]) == sb) && (r[7] != a[7]));
      exp_flags[CBP_FL_N] = sb;
      exp_flags[CBP_FL_C] = r[8];
   endfunction : exp_flags
   task automatic chk(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : chk
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   // Follows a cycle from its first low clock to its end
   task automatic track(input int k, input logic mk, input logic [15:0] a,
                        input int len);
      int n;
      n = 0;
      chk(fetch_cycle_marker === mk && addr_oe_n === 1'b0, "marker");
      while (strb[k] === 1'b0 && n < 12) begin
         chk(logical_address === a, "cycle address");
         n++;
         @(posedge clk_sys);
         #1;
      end
      chk(n == len, "cycle length");
   endtask : track
   task automatic fetch(input logic [15:0] a);
      int w;
      w = $urandom_range(3);
      n_wait <= 3'(w);
      instr_end <= 1'b1;
      @(posedge clk_sys);
      instr_end <= 1'b0;
      #1;
      track(0, 1'b0, a, 1 + w);
      chk(opcode === pat(a) && pc_out === a + 16'h1, "fetched byte");
   endtask : fetch
   task automatic bus_cyc(input logic [2:0] k, input logic [15:0] a,
                          input int w);
      logic [7:0] d;
      int         n;
      d = 8'($urandom);
      n_wait <= 3'(w);
      cyc_kind <= k;
      cyc_addr <= a;
      cyc_wdata <= d;
      cyc_req <= 1'b1;
      @(posedge clk_sys);
      cyc_req <= 1'b0;
      #1;
      if (k[0]) chk(bus_wdata === d, "write data");
      track(int'(k), 1'b1, a, (k[1] ? 2 : 1) + w);
      n = 0;
      while (cyc_done !== 1'b1 && n < 4) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(cyc_done === 1'b1, "cycle done");
      if (!k[0]) chk(rdata === pat(a), "read data");
   endtask : bus_cyc
   task automatic alu(input int m, input logic [7:0] a, input logic [7:0] b);
      logic [7:0] er, ef, msk;
      logic       s;
      s = 1'($urandom_range(1));
      ef = exp_flags(m, a, b, er);
      // Carry of logic ops is left open, so it is masked
      msk = (m == 2) ? 8'hC6 : 8'hD7;
      ld_a_value <= a;
      ld_a_special <= 1'b1;
      interrupt_enable_shadow <= s;
      @(posedge clk_sys);
      ld_a_special <= 1'b0;
      alu_go <= 1'b1;
      alu_op <= ops[m];
      alu_b <= b;
      #1;
      chk(flags_out[CBP_FL_PV] === s, "shadow copy");
      @(posedge clk_sys);
      alu_go <= 1'b0;
      #1;
      chk((flags_out & msk) === (ef & msk), "flags");
      chk(acc_out === er, "alu result");
   endtask : alu
   task automatic release_bus(input logic rep);
      int n;
      p = pc_out;
      n_wait <= 3'h0;
      bus_request_in <= 1'b0;
      repeat (3) begin
         @(posedge clk_sys);
         #1;
         chk(bus_grant_out === 1'b1, "grant off boundary");
      end
      rep_move <= rep;
      iter_end <= rep;
      instr_end <= !rep;
      @(posedge clk_sys);
      {rep_move, iter_end, instr_end} <= 3'h0;
      #1;
      repeat ($urandom_range(6, 2)) begin
         chk(bus_grant_out === 1'b0 && addr_oe_n === 1'b1, "grant");
         chk(int_block === 1'b1 && strb === 4'hF, "bus given up");
         @(posedge clk_sys);
         #1;
      end
      bus_request_in <= 1'b1;
      n = 0;
      while (!(rep ? bus_grant_out === 1'b1 : strb[0] === 1'b0) && n < 4) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(bus_grant_out === 1'b1, "grant returned");
      if (!rep) track(0, 1'b0, p, 1);
   endtask : release_bus
   // ==========================================================
   // Scenarios
   initial begin
      void'($urandom(24));
      repeat (8) @(posedge clk_sys);
      chk(strb === 4'hF && bus_grant_out === 1'b1, "reset outputs");
      chk(pc_out === CBP_PC_RESET && flags_out === CBP_FLAG_RST, "reset");
      rstn <= 1'b1;
      @(posedge clk_sys);
      fetch(16'h0000);
      fetch(16'h0001);
      for (int i = 0; i < 24; i++) begin
         bus_cyc(3'(i % 4), 16'($urandom), (i < 4) ? 0 : $urandom_range(3));
      end
      for (int i = 0; i < 3; i++) begin
         jump_target <= 16'($urandom);
         jump_take <= 1'b1;
         @(posedge clk_sys);
         jump_take <= 1'b0;
         fetch(jump_target);
         @(posedge clk_sys);
         #1;
         chk(fetch_cycle_marker === 1'b1 && opcode_valid === 1'b1, "kept");
      end
      for (int r = 0; r < 2; r++) begin
         p = pc_out;
         int_recog <= 1'b1;
         @(posedge clk_sys);
         int_recog <= 1'b0;
         #1;
         chk(saved_pc === p - 16'h1 && opcode_valid === 1'b0, "entry");
         ret_int <= (r == 0);
         ret_nmi <= (r == 1);
         ret_addr <= p - 16'h1;
         @(posedge clk_sys);
         {ret_int, ret_nmi} <= 2'h0;
         fetch(p - 16'h1);
      end
      alu(0, 8'h7F, 8'h01);
      alu(0, 8'hFF, 8'h01);
      alu(1, 8'h80, 8'h01);
      alu(1, 8'h10, 8'h01);
      alu(2, 8'h5A, 8'h5A);
      for (int i = 0; i < 12; i++) begin
         alu(i % 3, 8'($urandom), 8'($urandom));
      end
      release_bus(1'b0);
      release_bus(1'b1);
      end_of_test();
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      $display("wrong value at %0t: run did not finish", $time);
      end_of_test();
   end
endmodule : tb_top
